// ### sim/dual_gpio_port_bd_monitor.sv
// concurrent checks on the gpio block ports
`timescale 1ns/1ps
module dual_gpio_port_bd_monitor #(
    parameter B_WIDTH = 8,
    parameter D_WIDTH = 7
) (
    input wire               clock_i,
    input wire               rst_i,
    input wire               psel_i,
    input wire               penable_i,
    input wire               pwrite_i,
    input wire [9:0]         paddr_i,
    input wire [31:0]        prdata_o,
    input wire [B_WIDTH-1:0] b_pin_i,
    input wire [B_WIDTH-1:0] b_pin_oe_o,
    input wire [B_WIDTH-1:0] b_pullup_o,
    input wire [D_WIDTH-1:0] d_pin_i,
    input wire [D_WIDTH-1:0] d_pin_o,
    input wire [D_WIDTH-1:0] d_pin_oe_o,
    input wire [D_WIDTH-1:0] d_pullup_o,
    input wire               uart_txd_i,
    input wire               uart_tx_en_o,
    input wire               uart_rx_en_o,
    input wire               ext_irq_zero_o,
    input wire               ext_irq_one_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // apb access phases, ready is always high so each lasts one cycle
    wire rd_acc = psel_i && penable_i && !pwrite_i;
    wire wr_acc = psel_i && penable_i && pwrite_i;

    a_reset_float: assert property (disable iff (1'b0)
        rst_i |-> !(|b_pin_oe_o) && !(|d_pin_oe_o))
        else $error("pin driven during reset");
    a_pullup_input: assert property (
        ((b_pullup_o & b_pin_oe_o) == 0) && ((d_pullup_o & d_pin_oe_o) == 0))
        else $error("pull-up on a driven pin");
    a_pin_read: assert property (
        rd_acc && paddr_i == 10'h058 && !$past(rst_i, 3)
        |-> prdata_o[B_WIDTH-1:0] == $past(b_pin_i, 3))
        else $error("pin level read not two-stage synchronised");
    a_d_top_zero: assert property (
        rd_acc && paddr_i[9:3] == 7'h08 |-> prdata_o[31:7] == 25'h0)
        else $error("port d bit 7 reads nonzero");
    a_pin_write_inert: assert property (
        wr_acc && (paddr_i == 10'h040 || paddr_i == 10'h058)
        |=> $stable(b_pin_oe_o) && $stable(b_pullup_o) && $stable(d_pin_oe_o))
        else $error("pin level write changed port state");
    a_txd_forced: assert property (
        uart_tx_en_o |-> d_pin_oe_o[1] && d_pin_o[1] == uart_txd_i)
        else $error("transmit pin not forced out");
    a_rxd_input: assert property (uart_rx_en_o |-> !d_pin_oe_o[0])
        else $error("receive pin driven");
    a_irq_sync: assert property (
        !$past(rst_i) && !$past(rst_i, 2)
        |-> {ext_irq_one_o, ext_irq_zero_o} == $past(d_pin_i[3:2], 2))
        else $error("irq levels not synchronised pins");
    c_pin_write: cover property (wr_acc && paddr_i == 10'h058);
    c_pin_read: cover property (rd_acc && paddr_i == 10'h040);
    c_tx_on: cover property (uart_tx_en_o);
endmodule
bind dual_gpio_port_bd dual_gpio_port_bd_monitor #(.B_WIDTH(B_WIDTH), .D_WIDTH(D_WIDTH)) u_mon (
    .clock_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .prdata_o, .b_pin_i,
    .b_pin_oe_o, .b_pullup_o, .d_pin_i, .d_pin_o, .d_pin_oe_o, .d_pullup_o, .uart_txd_i,
    .uart_tx_en_o, .uart_rx_en_o, .ext_irq_zero_o, .ext_irq_one_o);

// ### sim/dual_gpio_port_bd_tb.sv
// testbench for the two-port gpio block: random port traffic plus alternate functions
`timescale 1ns/1ps
module dual_gpio_port_bd_tb;
    logic        clock_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, er;
    logic [9:0]  paddr_i = 0;
    logic [31:0] pwdata_i = 0, rd;
    logic        uart_txd_i = 0, timer1_match_out_i = 0, prog_dout_i = 0;
    logic [7:0]  b_ext_en = 0, b_ext_val = 0, bd, bl, bv, dv;
    logic [6:0]  d_ext_en = 0, d_ext_val = 0, dd, dl;
    integer      fail_count = 0, num_checks = 0, seed = 32'hEEA0A978, i;
    wire  [31:0] prdata_o;
    wire  [7:0]  b_pin_i, b_pin_o, b_pin_oe_o, b_pullup_o;
    wire  [6:0]  d_pin_i, d_pin_o, d_pin_oe_o, d_pullup_o;
    wire pready_o, pslverr_o, comparator_pos_in_o, comparator_neg_in_o, comparator_valid_o,
         uart_rxd_o, ext_irq_zero_o, ext_irq_one_o, timer0_ext_clock_o, timer1_ext_clock_o,
         capture_in_o, prog_sck_o, prog_din_o, uart_tx_en_o, uart_rx_en_o, serial_prog_o;
    dual_gpio_port_bd u_dut (.clock_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
        .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .b_pin_i, .b_pin_o, .b_pin_oe_o,
        .b_pullup_o, .d_pin_i, .d_pin_o, .d_pin_oe_o, .d_pullup_o, .uart_txd_i,
        .timer1_match_out_i, .prog_dout_i, .comparator_pos_in_o, .comparator_neg_in_o,
        .comparator_valid_o, .uart_rxd_o, .ext_irq_zero_o, .ext_irq_one_o,
        .timer0_ext_clock_o, .timer1_ext_clock_o, .capture_in_o, .prog_sck_o, .prog_din_o,
        .uart_tx_en_o, .uart_rx_en_o, .serial_prog_o);
    gpio_board_model #(.W(8)) u_bbrd (.clock_i, .oe_i(b_pin_oe_o), .out_i(b_pin_o),
        .pullup_i(b_pullup_o), .ext_en_i(b_ext_en), .ext_val_i(b_ext_val), .level_o(b_pin_i));
    gpio_board_model #(.W(7)) u_dbrd (.clock_i, .oe_i(d_pin_oe_o), .out_i(d_pin_o),
        .pullup_i(d_pullup_o), .ext_en_i(d_ext_en), .ext_val_i(d_ext_val), .level_o(d_pin_i));
    // 10 mhz clock
    always #50 clock_i = ~clock_i;
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask
    // one apb transfer, entered just after an edge; an idle cycle follows so psel is never
    // dropped and raised in one time step
    task apb(input logic wr, input logic [9:0] a, input logic [31:0] wd);
        psel_i <= 1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= wd;
        @(posedge clock_i) penable_i <= 1;
        do @(posedge clock_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 0;
        penable_i <= 0;
        @(posedge clock_i);
    endtask
    // pin level seen by the block: own drive on outputs, board drive on inputs
    function logic [7:0] lvl(input logic [7:0] dir, lat, ext);
        return (dir & lat) | (~dir & ext);
    endfunction
    task close_out;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // watchdog: the tests need well under 2000 cycles
    initial begin
        #500000;
        fail_count++;
        close_out;
    end
    initial begin
        repeat (6) @(posedge clock_i);
        rst_i <= 0;
        @(posedge clock_i);
        apb(0, 10'h05C, 0); chk("b dir reset", 0, rd);
        apb(0, 10'h060, 0); chk("b latch reset", 0, rd);
        apb(0, 10'h3FC, 0); chk("unmapped err", 1, er);
        apb(0, 10'h05D, 0); chk("unaligned err", 1, er);
        $display("test reset and address map done");
        for (i = 0; i < 16; i++) begin
            bd = $random(seed);
            bl = $random(seed);
            {dd, dl} = $random(seed);
            if (i < 2) begin
                bd = {8{i[0]}};
                bl = bd;
                dd = bd[6:0];
                dl = dd;
            end
            b_ext_en <= ~bd;
            b_ext_val <= $random(seed);
            d_ext_en <= ~dd;
            d_ext_val <= $random(seed);
            apb(1, 10'h05C, bd);
            apb(1, 10'h060, bl);
            apb(1, 10'h044, {1'b1, dd});
            apb(1, 10'h048, dl);
            apb(1, 10'h058, $random(seed));
            apb(1, 10'h040, $random(seed));
            bv = lvl(bd, bl, b_ext_val);
            dv = lvl({1'b0, dd}, {1'b0, dl}, {1'b0, d_ext_val});
            chk("b oe", bd, b_pin_oe_o);
            chk("b drive", bd & bl, b_pin_o & bd);
            chk("d oe", dd, d_pin_oe_o);
            chk("b pullup", ~bd & bl, b_pullup_o);
            chk("d pullup", ~dd & dl, d_pullup_o);
            chk("comparator", {bd[1:0] == 0 && bl[1:0] == 0, bv[1:0]},
                {comparator_valid_o, comparator_neg_in_o, comparator_pos_in_o});
            chk("d inputs", {dv[6:2], dv[0]}, {capture_in_o,
                timer1_ext_clock_o, timer0_ext_clock_o, ext_irq_one_o, ext_irq_zero_o,
                uart_rxd_o});
            apb(0, 10'h05C, 0); chk("b dir", bd, rd);
            apb(0, 10'h060, 0); chk("b latch", bl, rd);
            apb(0, 10'h044, 0); chk("d dir", dd, rd);
            apb(0, 10'h048, 0); chk("d latch", dl, rd);
            apb(0, 10'h058, 0); chk("b pins", bv, rd);
            apb(0, 10'h040, 0); chk("d pins", dv, rd);
        end
        $display("test random ports done");
        b_ext_en <= 8'hB7;
        d_ext_en <= 7'h7D;
        uart_txd_i <= $random(seed);
        timer1_match_out_i <= $random(seed);
        prog_dout_i <= $random(seed);
        apb(1, 10'h05C, 8'h08);
        apb(1, 10'h044, 8'h01);
        apb(1, 10'h048, 8'h01);
        apb(1, 10'h080, 8'h0F);
        repeat (2) @(posedge clock_i);
        chk("modes", 3'h7, {serial_prog_o, uart_rx_en_o, uart_tx_en_o});
        chk("txd pin", {1'b1, uart_txd_i}, {d_pin_oe_o[1], d_pin_o[1]});
        chk("rxd pin", 2'h1, {d_pin_oe_o[0], d_pullup_o[0]});
        chk("match pin", {1'b1, timer1_match_out_i}, {b_pin_oe_o[3], b_pin_o[3]});
        chk("prog out", {1'b1, prog_dout_i}, {b_pin_oe_o[6], b_pin_o[6]});
        chk("prog in", {b_ext_val[7], b_ext_val[5]}, {prog_sck_o, prog_din_o});
        $display("test alternate functions done");
        rst_i <= 1;
        #10;
        chk("reset float", 0, {b_pin_oe_o, d_pin_oe_o, b_pullup_o, d_pullup_o});
        repeat (6) @(posedge clock_i);
        rst_i <= 0;
        @(posedge clock_i);
        apb(0, 10'h05C, 0); chk("b dir reset", 0, rd);
        $display("test mid-run reset done");
        close_out;
    end
endmodule

// ### sim/gpio_board_model.sv
// board-side pin model: resolves each pin from device drive, board drive and pull-up
`timescale 1ns/1ps
module gpio_board_model #(
    parameter W = 8
) (
    input  wire          clock_i,
    input  wire  [W-1:0] oe_i,
    input  wire  [W-1:0] out_i,
    input  wire  [W-1:0] pullup_i,
    input  wire  [W-1:0] ext_en_i,
    input  wire  [W-1:0] ext_val_i,
    output logic [W-1:0] level_o
);
    logic [W-1:0] float_ff = '0;
    // an undriven pin with no pull-up wanders, so nobody may rely on its last level
    always @(posedge clock_i) begin
        float_ff <= ~level_o;
    end
    // device drive wins over the board, the board over the pull-up
    always @* begin
        level_o = (oe_i & out_i) | (~oe_i & ext_en_i & ext_val_i)
                | (~oe_i & ~ext_en_i & (pullup_i | float_ff));
    end
endmodule

// ### verilog/dual_gpio_port_bd.v
// two-port gpio block (port b eight pins, port d seven pins) with apb register access
// Summary of operation
// - pin-level reads give synchronised pin levels; latch reads give stored latch
// - direction one drives latch value push-pull; direction zero makes pin input
// - pull-up on only for an input pin whose latch bit is one
// - reset tri-states every pin at once, with no clock needed
// - port d has seven pins; bit 7 of direction and pin levels reads zero
// - every pin input is synchronised before any reader sees it
// - port b bits 1,0 feed comparator inputs while input with pull-up off
// - uart transmit enable forces port d bit 1 to output transmit data
// - uart receive enable forces port d bit 0 input; latch still sets pull-up
// - port d bits 2,3 give synchronised levels as external irq 0 and 1
// - port d bits 4,5 give timer clocks; bit 6 gives capture input
// - serial programming uses port b bit 7 clock, 6 data out, 5 data in
// - pin-level addresses read only; latch and direction registers read/write
// - port b latch and direction are eight bits at 0x18, 0x17, reset zero
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`include "gpio_bd_defines.vh"
module dual_gpio_port_bd #(
    parameter B_WIDTH = 8,
    parameter D_WIDTH = 7
) (
    // clock and reset
    input  wire               clock_i,
    input  wire               rst_i,
    // apb slave
    input  wire               psel_i,
    input  wire               penable_i,
    input  wire               pwrite_i,
    input  wire [9:0]         paddr_i,
    input  wire [31:0]        pwdata_i,
    output wire [31:0]        prdata_o,
    output wire               pready_o,
    output wire               pslverr_o,
    // port b pins
    input  wire [B_WIDTH-1:0] b_pin_i,
    output wire [B_WIDTH-1:0] b_pin_o,
    output wire [B_WIDTH-1:0] b_pin_oe_o,
    output wire [B_WIDTH-1:0] b_pullup_o,
    // port d pins
    input  wire [D_WIDTH-1:0] d_pin_i,
    output wire [D_WIDTH-1:0] d_pin_o,
    output wire [D_WIDTH-1:0] d_pin_oe_o,
    output wire [D_WIDTH-1:0] d_pullup_o,
    // peripheral side
    input  wire               uart_txd_i,
    input  wire               timer1_match_out_i,
    input  wire               prog_dout_i,
    output wire               comparator_pos_in_o,
    output wire               comparator_neg_in_o,
    output wire               comparator_valid_o,
    output wire               uart_rxd_o,
    output wire               ext_irq_zero_o,
    output wire               ext_irq_one_o,
    output wire               timer0_ext_clock_o,
    output wire               timer1_ext_clock_o,
    output wire               capture_in_o,
    output wire               prog_sck_o,
    output wire               prog_din_o,
    output wire               uart_tx_en_o,
    output wire               uart_rx_en_o,
    output wire               serial_prog_o
);

    // software-visible state
    reg  [B_WIDTH-1:0] port_b_output_latch_ff;
    reg  [B_WIDTH-1:0] port_b_direction_ff;
    reg  [D_WIDTH-1:0] port_d_output_latch_ff;
    reg  [D_WIDTH-1:0] port_d_direction_ff;
    reg  [3:0]         alt_control_ff;
    reg  [31:0]        prdata_ff;
    reg  [31:0]        nxt_prdata;
    reg                pslverr_ff;
    reg                nxt_pslverr;

    wire [B_WIDTH-1:0] b_sync;
    wire [D_WIDTH-1:0] d_sync;
    wire [7:0]         reg_index;
    wire               addr_aligned;
    wire               access;
    wire               wr_strobe;
    wire               mapped;

    wire uart_tx_en    = alt_control_ff[`ALT_UART_TX_EN_BIT];
    wire uart_rx_en    = alt_control_ff[`ALT_UART_RX_EN_BIT];
    wire serial_prog   = alt_control_ff[`ALT_SERIAL_PROG_BIT];
    wire timer1_out_en = alt_control_ff[`ALT_TIMER1_OUT_EN_BIT];

    // pin inputs pass through two flops before any consumer
    pin_sync #(.WIDTH(B_WIDTH)) u_b_sync (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .async_i (b_pin_i),
        .sync_o  (b_sync)
    );

    pin_sync #(.WIDTH(D_WIDTH)) u_d_sync (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .async_i (d_pin_i),
        .sync_o  (d_sync)
    );

    // register map, byte address = index times four:
    //   0x40  port d pin levels, read only, bit 7 reads zero
    //   0x44  port d direction, bits 6..0, bit 7 reads zero
    //   0x48  port d output latch, bits 6..0
    //   0x58  port b pin levels, read only
    //   0x5C  port b direction, eight bits
    //   0x60  port b output latch, eight bits
    //   0x80  alternate-function control, four bits
    // everything else answers with an error and reads zero
    // writes to the two pin-level words are dropped silently,
    // since a stray store there must never disturb a pin
    // unaligned byte addresses are treated as unmapped so a
    // narrow master cannot hit a register by accident
    // upper address bits above the index are not decoded
    // because the bus is only ten bits wide
    //
    // apb decode: byte address is register index times four
    assign reg_index    = paddr_i[9:2];
    assign addr_aligned = (paddr_i[1:0] == 2'b00);
    assign access       = psel_i & penable_i;
    assign wr_strobe    = access & pwrite_i;
    assign mapped = addr_aligned &
                    ((reg_index == `IDX_PORT_D_PIN_LEVELS) ||
                     (reg_index == `IDX_PORT_D_DIRECTION) ||
                     (reg_index == `IDX_PORT_D_OUTPUT_LATCH) ||
                     (reg_index == `IDX_PORT_B_PIN_LEVELS) ||
                     (reg_index == `IDX_PORT_B_DIRECTION) ||
                     (reg_index == `IDX_PORT_B_OUTPUT_LATCH) ||
                     (reg_index == `IDX_ALT_CONTROL));

    // timing of a transfer:
    //   setup edge   read mux and error flag are captured
    //   access edge  write lands, master takes read data
    // read data is a flop so the pins never see a long path
    // from the synchronisers straight onto the bus
    // the trade-off is that a pin-level read returns the
    // value that stood at the setup edge, one cycle older
    // than a combinational mux would give
    // the error flag follows the same capture so both
    // stand unchanged for the whole access phase
    //
    // zero wait states: access phase completes in its first cycle
    assign pready_o  = 1'b1;
    assign prdata_o  = prdata_ff;
    assign pslverr_o = pslverr_ff;

    // read mux, sampled in the setup cycle so data is a flop in the access cycle
    always @* begin
        nxt_prdata  = `ZERO_WORD;
        nxt_pslverr = 1'b0;
        if (psel_i && !penable_i) begin
            nxt_pslverr = ~mapped;
            if (addr_aligned && !pwrite_i) begin
                case (reg_index)
                    `IDX_PORT_B_PIN_LEVELS:   nxt_prdata[B_WIDTH-1:0] = b_sync;
                    `IDX_PORT_B_OUTPUT_LATCH: nxt_prdata[B_WIDTH-1:0] = port_b_output_latch_ff;
                    `IDX_PORT_B_DIRECTION:    nxt_prdata[B_WIDTH-1:0] = port_b_direction_ff;
                    `IDX_PORT_D_PIN_LEVELS:   nxt_prdata[D_WIDTH-1:0] = d_sync;
                    `IDX_PORT_D_OUTPUT_LATCH: nxt_prdata[D_WIDTH-1:0] = port_d_output_latch_ff;
                    `IDX_PORT_D_DIRECTION:    nxt_prdata[D_WIDTH-1:0] = port_d_direction_ff;
                    `IDX_ALT_CONTROL:         nxt_prdata[3:0] = alt_control_ff;
                    default:                  nxt_prdata = `ZERO_WORD;
                endcase
            end
        end
    end

    // read data and error are held through the access phase
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            prdata_ff  <= `ZERO_WORD;
            pslverr_ff <= 1'b0;
        end else if (psel_i && !penable_i) begin
            prdata_ff  <= nxt_prdata;
            pslverr_ff <= nxt_pslverr;
        end
    end

    // register writes; pin-level indices have no write path at all
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            port_b_output_latch_ff <= `PORT_RESET_VALUE;
            port_b_direction_ff    <= `PORT_RESET_VALUE;
            port_d_output_latch_ff <= {D_WIDTH{1'b0}};
            port_d_direction_ff    <= {D_WIDTH{1'b0}};
            alt_control_ff         <= `ALT_RESET_VALUE;
        end else if (wr_strobe && addr_aligned) begin
            case (reg_index)
                `IDX_PORT_B_OUTPUT_LATCH: port_b_output_latch_ff <= pwdata_i[B_WIDTH-1:0];
                `IDX_PORT_B_DIRECTION:    port_b_direction_ff <= pwdata_i[B_WIDTH-1:0];
                `IDX_PORT_D_OUTPUT_LATCH: port_d_output_latch_ff <= pwdata_i[D_WIDTH-1:0];
                `IDX_PORT_D_DIRECTION:    port_d_direction_ff <= pwdata_i[D_WIDTH-1:0];
                `IDX_ALT_CONTROL:         alt_control_ff <= pwdata_i[3:0];
                default:                  alt_control_ff <= alt_control_ff;
            endcase
        end
    end

    // port b override priority, highest first:
    //   serial programming data out on bit 6 (forced output)
    //   timer match output on bit 3 (direction from software)
    //   plain latch value
    // the match output does not force the direction bit:
    // software must set it, otherwise the pin stays an input
    // and the timer value is simply not seen outside
    // programming clock and data in (bits 7 and 5) stay
    // inputs under software control; only their synchronised
    // levels are gated towards the programming logic
    // the pull-up follows the effective direction, so a
    // forced output never fights its own pull-up
    // oe and pull-up are masked by the reset level itself,
    // not only by the flops, so a reset with the clock
    // stopped still floats every pin
    //
    // port b drive; registers reset asynchronously so pins float at once
    genvar gi;
    generate
        for (gi = 0; gi < B_WIDTH; gi = gi + 1) begin : g_b
            wire is_prog_out = serial_prog && (gi == `B_PROG_DOUT_BIT);
            wire is_match    = timer1_out_en && (gi == `B_MATCH_OUT_BIT);
            wire dir_out     = port_b_direction_ff[gi] | is_prog_out;
            assign b_pin_oe_o[gi] = dir_out & ~rst_i;
            assign b_pin_o[gi]    = is_prog_out ? prog_dout_i :
                                    is_match    ? timer1_match_out_i :
                                    port_b_output_latch_ff[gi];
            assign b_pullup_o[gi] = ~dir_out & port_b_output_latch_ff[gi] & ~rst_i;
        end
    endgenerate

    // port d overrides:
    //   transmit enable forces bit 1 out with transmit data
    //   receive enable forces bit 0 in, whatever direction says
    // the receive pin keeps its latch-controlled pull-up so
    // an idle line can be held high without a board resistor
    // bits 2..6 have no drive overrides; their alternate uses
    // are all inputs and only tap the synchronised level
    // if both uart enables and the direction bits disagree
    // the forced setting wins, software cannot override it
    //
    // port d drive with uart overrides on bits 0 and 1
    generate
        for (gi = 0; gi < D_WIDTH; gi = gi + 1) begin : g_d
            wire force_out = uart_tx_en && (gi == `D_TXD_BIT);
            wire force_in  = uart_rx_en && (gi == `D_RXD_BIT);
            wire dir_out   = (port_d_direction_ff[gi] | force_out) & ~force_in;
            assign d_pin_oe_o[gi] = dir_out & ~rst_i;
            assign d_pin_o[gi]    = force_out ? uart_txd_i : port_d_output_latch_ff[gi];
            assign d_pullup_o[gi] = ~dir_out & port_d_output_latch_ff[gi] & ~rst_i;
        end
    endgenerate

    // comparator inputs valid only while both pins are inputs with pull-up off
    assign comparator_pos_in_o = b_sync[`B_COMP_POS_BIT];
    assign comparator_neg_in_o = b_sync[`B_COMP_NEG_BIT];
    assign comparator_valid_o  = ~port_b_direction_ff[`B_COMP_POS_BIT] &
                                 ~port_b_output_latch_ff[`B_COMP_POS_BIT] &
                                 ~port_b_direction_ff[`B_COMP_NEG_BIT] &
                                 ~port_b_output_latch_ff[`B_COMP_NEG_BIT];

    // alternate inputs always come from the second flop stage
    // so every consumer sees the same value in the same cycle
    // as a pin-level read would; a consumer wanting edges
    // must detect them itself on these levels
    // latency from pin to consumer is two clock edges
    // the interrupt, timer clock and capture taps are not
    // gated by direction: an output pin feeds back its own
    // drive, which software may use to raise an interrupt
    // the programming taps are gated so that a toggling
    // pin in normal use cannot look like a programming clock
    // mode enables are exported as registered levels so the
    // uart and programming logic need no decode of their own
    //
    // synchronised alternate inputs to other blocks
    assign uart_rxd_o         = d_sync[`D_RXD_BIT];
    assign ext_irq_zero_o     = d_sync[`D_IRQ0_BIT];
    assign ext_irq_one_o      = d_sync[`D_IRQ1_BIT];
    assign timer0_ext_clock_o = d_sync[`D_T0_BIT];
    assign timer1_ext_clock_o = d_sync[`D_T1_BIT];
    assign capture_in_o       = d_sync[`D_CAPTURE_BIT];
    assign prog_sck_o         = serial_prog & b_sync[`B_PROG_SCK_BIT];
    assign prog_din_o         = serial_prog & b_sync[`B_PROG_DIN_BIT];
    assign uart_tx_en_o       = uart_tx_en;
    assign uart_rx_en_o       = uart_rx_en;
    assign serial_prog_o      = serial_prog;

endmodule

// ### verilog/gpio_bd_defines.vh
// register offsets, widths and reset values for the two-port gpio block
`ifndef GPIO_BD_DEFINES_VH
`define GPIO_BD_DEFINES_VH

// register indices as printed (not multiples of four: byte address = index * 4)
`define IDX_PORT_D_PIN_LEVELS    8'h10
`define IDX_PORT_D_DIRECTION     8'h11
`define IDX_PORT_D_OUTPUT_LATCH  8'h12
`define IDX_PORT_B_PIN_LEVELS    8'h16
`define IDX_PORT_B_DIRECTION     8'h17
`define IDX_PORT_B_OUTPUT_LATCH  8'h18
`define IDX_ALT_CONTROL          8'h20

// alternate-function control register fields
`define ALT_UART_TX_EN_BIT       0
`define ALT_UART_RX_EN_BIT       1
`define ALT_SERIAL_PROG_BIT      2
`define ALT_TIMER1_OUT_EN_BIT    3

// pin positions
`define B_COMP_POS_BIT           0
`define B_COMP_NEG_BIT           1
`define B_MATCH_OUT_BIT          3
`define B_PROG_DIN_BIT           5
`define B_PROG_DOUT_BIT          6
`define B_PROG_SCK_BIT           7
`define D_RXD_BIT                0
`define D_TXD_BIT                1
`define D_IRQ0_BIT               2
`define D_IRQ1_BIT               3
`define D_T0_BIT                 4
`define D_T1_BIT                 5
`define D_CAPTURE_BIT            6

// reset values
`define PORT_RESET_VALUE         8'h00
`define ALT_RESET_VALUE          4'h0
`define ZERO_WORD                32'h00000000

`endif

// ### verilog/pin_sync.v
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pin_sync #(
    parameter WIDTH = 8
) (
    // clock and reset
    input  wire             clock_i,
    input  wire             rst_i,
    // raw and synchronised levels
    input  wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);

    reg [WIDTH-1:0] stage1_ff;
    reg [WIDTH-1:0] stage2_ff;

    // first stage feeds only the second stage
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            stage1_ff <= {WIDTH{1'b0}};
            stage2_ff <= {WIDTH{1'b0}};
        end else begin
            stage1_ff <= async_i;
            stage2_ff <= stage1_ff;
        end
    end

    assign sync_o = stage2_ff;

endmodule
